// >>> event_flag.sv
// Sticky event flag: hardware sets, software clears, set wins
`timescale 1ns/1ps
`default_nettype none

module event_flag (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Set and clear strobes
  input  wire logic set,
  input  wire logic clr,
  // Held flag
  output var  logic flag
);

  logic next_flag;  // Next flag value

  // Set has priority over a clear in the same cycle
  always_comb begin
    next_flag = flag;
    if (clr) begin
      next_flag = 1'b0;
    end
    if (set) begin
      next_flag = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

// >>> two_wire_engine_model.sv
// Serial engine stand-in: replays commanded pulses one cycle later
`timescale 1ns/1ps
`default_nettype none
module two_wire_engine_model (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // Pulse command from the bench
  input wire logic [8:0] req,
  // Pulses toward the block
  output var logic       byte_start, halt_done_event, receive_byte_ready_event,
  output var logic       transmit_byte_sent_event, error_event, read_ack_done,
  output var logic       pause_request, halt_request, resume_request
);
  logic [8:0] out_q, next_out; // Registered pulses
  // Next pulse set
  always_comb next_out = req;
  // One-cycle pulses, quiet in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) out_q <= '0;
    else out_q <= next_out;
  end
  assign {resume_request, halt_request, pause_request, read_ack_done, error_event,
          transmit_byte_sent_event, receive_byte_ready_event, halt_done_event,
          byte_start} = out_q;
endmodule
`default_nettype wire

// >>> two_wire_irq_and_shortcut_ctrl.sv
// Event-to-task shortcuts and interrupt enables of a two-wire master
// What this block does
// - Boundary event triggers pause when shortcut set
// - Boundary event triggers halt when shortcut set
// - Shortcut register read-write, resets to zero
// - Enable-set register: write one enables event
// - Enable-clear register: write one disables event
// - Six separate enables, reachable through both registers
// - Paused event only after read ack, if requested
// - Both enable registers read zero after reset
// - Boundary event produced before every byte
`timescale 1ns/1ps
`default_nettype none

`include "two_wire_regs.svh"

// Timing seen from outside
// - Bus access phase lasts two cycles; pready is a one-cycle pulse
// - A write lands on the edge that samples pready high
// - Boundary pulse follows byte_start by one cycle
// - Shortcut tasks follow the boundary pulse by one cycle
// - Paused event follows the read ack by one cycle
// - Flags set one cycle after their event, irq one cycle later
// All event inputs are pulses on pclk, so no synchroniser is used

module two_wire_irq_and_shortcut_ctrl #(
  parameter int unsigned ADDR_W = 12  // Register bus address width
) (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // Register bus
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  // Event sources from the serial engine
  input  wire logic                    byte_start,
  input  wire logic                    halt_done_event,
  input  wire logic                    receive_byte_ready_event,
  input  wire logic                    transmit_byte_sent_event,
  input  wire logic                    error_event,
  input  wire logic                    read_ack_done,
  // Explicit task requests
  input  wire logic                    pause_request,
  input  wire logic                    halt_request,
  input  wire logic                    resume_request,
  // Events and tasks toward the serial engine
  output var  logic                    byte_boundary_event,
  output var  logic                    pause_task,
  output var  logic                    halt_task,
  output var  logic                    paused_event,
  // Interrupt side
  output var  two_wire_pkg::event_vec_t event_flags,
  output var  logic                    irq
);
  import two_wire_pkg::*;

  // Register bus state
  apb_phase_e               phase;          // Answer sequencing
  apb_phase_e               next_phase;     // Next answer step

  // Next values of the bus answer registers
  logic [31:0]              next_prdata;    // Read data to present
  logic                     next_pready;
  logic                     next_pslverr;   // Error flag to present

  // Decode and commit strobes
  logic                     addr_hit;       // Address is mapped
  logic                     wr_commit;      // Write takes effect now

  // Control and status state
  logic [`SC_WIDTH-1:0]     shortcuts;      // Shortcut fields
  logic [`SC_WIDTH-1:0]     next_shortcuts;
  event_vec_t               irq_enable;     // Interrupt enables
  event_vec_t               next_irq_enable;
  event_vec_t               flag_clr;       // Status clear strobes
  event_vec_t               event_raw;      // Event pulses into flags

  // Pause tracking between request and read ack
  logic                     pause_pending;  // Pause requested, not yet taken
  logic                     next_pause_pending;

  // Next values of the registered strobes
  logic                     next_boundary;  // Boundary pulse
  logic                     next_pause_task;
  logic                     next_halt_task;
  logic                     next_paused;
  logic                     next_irq;

  // Address decode of the mapped words
  // Exact word match only; any other address answers with an error
  always_comb begin
    case (paddr)
      `EVENT_TASK_SHORTCUTS_OFS: addr_hit = 1'b1;
      `IRQ_ENABLE_SET_OFS:       addr_hit = 1'b1;
      `IRQ_ENABLE_CLEAR_OFS:     addr_hit = 1'b1;
      `EVENT_STATUS_OFS:         addr_hit = 1'b1;
      `EVENT_STATUS_CLEAR_OFS:   addr_hit = 1'b1;
      default:                   addr_hit = 1'b0;
    endcase
  end

  // Write lands on the edge that samples pready high
  // Gating with the answer phase keeps one access from writing twice
  assign wr_commit = (phase == apb_answer) && psel && penable && pwrite && addr_hit;

  // Bus answer: one wait cycle, then pready for one cycle
  // A new access is only taken once the previous answer is gone
  always_comb begin
    next_phase   = phase;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    case (phase)
      apb_idle: begin
        // Access phase seen: prepare the answer
        if (psel && penable) begin
          next_phase   = apb_answer;
          next_pready  = 1'b1;
          next_pslverr = !addr_hit;
          // Writes and unmapped reads answer zero
          next_prdata  = 32'h0000_0000;
          // Read data captured now, shown together with pready
          if (!pwrite) begin
            case (paddr)
              // Shortcut fields read back as written
              `EVENT_TASK_SHORTCUTS_OFS: next_prdata = 32'(shortcuts);
              // Both enable words show the same state
              `IRQ_ENABLE_SET_OFS:       next_prdata = 32'(irq_enable);
              `IRQ_ENABLE_CLEAR_OFS:     next_prdata = 32'(irq_enable);
              // Sticky status of all events
              `EVENT_STATUS_OFS:         next_prdata = 32'(event_flags);
              // Clear word is write-only
              default:                   next_prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      apb_answer: begin
        // Answer taken, drop pready
        // Master releases psel and penable after this edge
        next_phase = apb_idle;
      end
      default: begin
        next_phase = apb_idle;
      end
    endcase
  end

  // Bus answer registers
  // prdata keeps its value between answers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase   <= apb_idle;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      phase   <= next_phase;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Software writes to shortcut and enable words
  // Enable words act bitwise so other enables stay untouched
  always_comb begin
    next_shortcuts  = shortcuts;
    next_irq_enable = irq_enable;
    flag_clr        = '0;
    // Unmapped writes change nothing; pslverr reports them
    if (wr_commit) begin
      case (paddr)
        // Plain read-write shortcut fields
        `EVENT_TASK_SHORTCUTS_OFS: begin
          next_shortcuts = pwdata[`SC_WIDTH-1:0];
        end
        // Ones set enables, zeros leave them
        `IRQ_ENABLE_SET_OFS: begin
          next_irq_enable = irq_enable | pwdata[`EV_COUNT-1:0];
        end
        // Ones clear enables, zeros leave them
        `IRQ_ENABLE_CLEAR_OFS: begin
          next_irq_enable = irq_enable & ~pwdata[`EV_COUNT-1:0];
        end
        // Ones clear sticky flags
        `EVENT_STATUS_CLEAR_OFS: begin
          flag_clr = pwdata[`EV_COUNT-1:0];
        end
        // Status word ignores writes
        default: begin
          flag_clr = '0;
        end
      endcase
    end
  end

  // Control registers
  // Both shortcuts and all enables start cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shortcuts  <= `SHORTCUTS_RESET;
      irq_enable <= `IRQ_ENABLE_RESET;
    end else begin
      shortcuts  <= next_shortcuts;
      irq_enable <= next_irq_enable;
    end
  end

  // Events, shortcut tasks and pause tracking
  always_comb begin
    // Boundary pulse ahead of each byte
    next_boundary = byte_start;
    // A request together with a boundary still gives one task
    // Boundary fires pause only when its shortcut is on
    next_pause_task = pause_request
                      || (byte_boundary_event && shortcuts[`SC_PAUSE_BIT]);
    // Boundary fires halt only when its shortcut is on
    next_halt_task = halt_request
                     || (byte_boundary_event && shortcuts[`SC_HALT_BIT]);
    // A pause armed in this very cycle waits for the next ack
    // Paused only after a read ack with a pause already pending
    next_paused = read_ack_done && pause_pending;
    next_pause_pending = pause_pending;
    // Pending pause ends when taken or resumed
    if (next_paused || resume_request) begin
      next_pause_pending = 1'b0;
    end
    // Resume and a new pause in one cycle: the pause stays armed
    // A new pause task arms the pending state
    if (pause_task) begin
      next_pause_pending = 1'b1;
    end
  end

  // Event and task registers
  // Every task and event output is a one-cycle strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte_boundary_event <= 1'b0;
      pause_task          <= 1'b0;
      halt_task           <= 1'b0;
      paused_event        <= 1'b0;
      pause_pending       <= 1'b0;
    end else begin
      byte_boundary_event <= next_boundary;
      pause_task          <= next_pause_task;
      halt_task           <= next_halt_task;
      paused_event        <= next_paused;
      pause_pending       <= next_pause_pending;
    end
  end

  // Event pulses routed to their flag positions
  // Same bit layout as the enable registers
  always_comb begin
    event_raw                    = '0;
    event_raw[`EV_HALT_DONE_BIT] = halt_done_event;
    event_raw[`EV_RX_READY_BIT]  = receive_byte_ready_event;
    event_raw[`EV_TX_SENT_BIT]   = transmit_byte_sent_event;
    event_raw[`EV_ERROR_BIT]     = error_event;
    event_raw[`EV_BOUNDARY_BIT]  = byte_boundary_event;
    event_raw[`EV_PAUSED_BIT]    = paused_event;
  end

  // One sticky flag per event
  // A software clear that meets its event loses to the event
  for (genvar i = 0; i < `EV_COUNT; i++) begin : g_flag
    event_flag u_flag (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (event_raw[i]),
      .clr     (flag_clr[i]),
      .flag    (event_flags[i])
    );
  end

  // Interrupt level from enabled flags
  // Clearing an enable or a flag drops irq one cycle later
  always_comb begin
    next_irq = |(event_flags & irq_enable);
  end

  // Interrupt register
  // Registered so the line never glitches while flags change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

endmodule

`default_nettype wire

// >>> two_wire_irq_and_shortcut_ctrl_tb_top.sv
// Self-checking bench for the two-wire shortcut and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.svh"
module two_wire_irq_and_shortcut_ctrl_tb_top;
  import two_wire_pkg::*;
  logic        pclk = 0, presetn = 0;            // Clock and reset
  logic        psel = 0, penable = 0, pwrite = 0; // Bus request
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr;
  logic [8:0]  req = '0;                          // Engine command
  logic        byte_start, halt_done_event, receive_byte_ready_event;
  logic        transmit_byte_sent_event, error_event, read_ack_done;
  logic        pause_request, halt_request, resume_request;
  logic        byte_boundary_event, pause_task, halt_task, paused_event, irq;
  event_vec_t  event_flags;
  logic [33:0] q[$];                              // Expected {read, error, data}
  int          miscompares = 0, compares = 0;
  int          pause_seen = 0, halt_seen = 0;     // Task pulses seen
  always #2 pclk = ~pclk;
  two_wire_engine_model eng_u (.pclk, .presetn, .req, .byte_start, .halt_done_event,
    .receive_byte_ready_event, .transmit_byte_sent_event, .error_event, .read_ack_done,
    .pause_request, .halt_request, .resume_request);
  two_wire_irq_and_shortcut_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .byte_start, .halt_done_event,
    .receive_byte_ready_event, .transmit_byte_sent_event, .error_event, .read_ack_done,
    .pause_request, .halt_request, .resume_request, .byte_boundary_event, .pause_task,
    .halt_task, .paused_event, .event_flags, .irq);
  // Compare and count
  task chk(string name, logic [32:0] seen, logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict
  task end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One bus transfer, expectation noted in the queue
  task apb(logic wr, logic [11:0] a, logic [31:0] d, logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    q.push_back({!wr, exp});
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (!pready && n < 16);
    if (!pready) begin miscompares++; end_of_test(); end
    psel <= 0; penable <= 0;
  endtask
  // One engine pulse, then settle
  task pulse(logic [8:0] v);
    @(posedge pclk); req <= v;
    @(posedge pclk); req <= '0;
    repeat (4) @(posedge pclk);
  endtask
  // Answer watcher
  always @(posedge pclk) if (psel && penable && pready) begin
    chk("bus", {pslverr, q[0][33] ? prdata : 32'h0}, q[0][32:0]);
    void'(q.pop_front());
  end
  // Task pulse counter
  always @(posedge pclk) begin
    if (pause_task) pause_seen++;
    if (halt_task) halt_seen++;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [5:0]  acc;
    void'($urandom(87668));
    repeat (16) @(posedge pclk);
    presetn <= 1;
    apb(0, `EVENT_TASK_SHORTCUTS_OFS, 0, 0);
    apb(0, `IRQ_ENABLE_SET_OFS, 0, 0);
    apb(0, `IRQ_ENABLE_CLEAR_OFS, 0, 0);
    r = $urandom;
    apb(1, `EVENT_TASK_SHORTCUTS_OFS, r, 0);
    apb(0, `EVENT_TASK_SHORTCUTS_OFS, 0, {31'h0, r[1:0]});
    acc = '0;
    for (int i = 0; i < 6; i++) begin
      acc[i] = 1'b1;
      apb(1, `IRQ_ENABLE_SET_OFS, 32'h1 << i, 0);
      apb(0, `IRQ_ENABLE_CLEAR_OFS, 0, {27'h0, acc});
    end
    for (int i = 0; i < 6; i++) begin
      acc[i] = 1'b0;
      apb(1, `IRQ_ENABLE_CLEAR_OFS, 32'h1 << i, 0);
      apb(0, `IRQ_ENABLE_SET_OFS, 0, {27'h0, acc});
    end
    apb(0, 12'h0FC, 0, {1'b1, 32'h0});
    // Flags raise the interrupt only while enabled
    apb(1, `IRQ_ENABLE_SET_OFS, 32'h3F, 0);
    for (int i = 1; i < 5; i++) pulse(9'h1 << i);
    apb(0, `EVENT_STATUS_OFS, 0, 33'h0F);
    chk("irq", irq, 33'h1);
    apb(1, `IRQ_ENABLE_CLEAR_OFS, 32'h3F, 0);
    repeat (3) @(posedge pclk);
    chk("irq", irq, 33'h0);
    // Boundary with both shortcuts, then read ack
    apb(1, `EVENT_STATUS_CLEAR_OFS, 32'h3F, 0);
    apb(1, `EVENT_TASK_SHORTCUTS_OFS, 32'h3, 0);
    pulse(9'h001);
    pulse(9'h020);
    apb(0, `EVENT_STATUS_OFS, 0, 33'h30);
    chk("pause_task", pause_seen, 33'h1);
    chk("halt_task", halt_seen, 33'h1);
    // Shortcuts off, explicit pause undone by resume
    apb(1, `EVENT_STATUS_CLEAR_OFS, 32'h3F, 0);
    apb(1, `EVENT_TASK_SHORTCUTS_OFS, 32'h0, 0);
    pulse(9'h080);
    pulse(9'h040);
    pulse(9'h100);
    pulse(9'h001);
    pulse(9'h020);
    apb(0, `EVENT_STATUS_OFS, 0, 33'h10);
    chk("pause_task", pause_seen, 33'h2);
    chk("halt_task", halt_seen, 33'h2);
    end_of_test();
  end
endmodule
bind two_wire_irq_and_shortcut_ctrl two_wire_irq_assertions chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .paddr, .pwdata, .prdata, .byte_start, .read_ack_done,
  .pause_request, .halt_request, .byte_boundary_event, .pause_task, .halt_task,
  .paused_event, .irq, .event_flags);
`default_nettype wire

// >>> two_wire_irq_assertions.sv
// Assertion checker for the two-wire shortcut and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "two_wire_regs.svh"
module two_wire_irq_assertions (
  // Clock, reset and register bus
  input wire logic                     pclk, presetn, psel, penable, pwrite, pready,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata, prdata,
  // Requests and results
  input wire logic                     byte_start, read_ack_done, pause_request, halt_request,
  input wire logic                     byte_boundary_event, pause_task, halt_task, paused_event,
  input wire logic                     irq,
  input wire two_wire_pkg::event_vec_t event_flags
);
  logic [1:0] sc, next_sc; // Shadow of the shortcut bits
  logic [5:0] en, next_en; // Shadow of the enables
  logic       wr;          // Committed write
  assign wr = psel & penable & pready & pwrite;
  // Track what software wrote
  always_comb begin
    next_sc = sc;
    next_en = en;
    if (wr && paddr == `EVENT_TASK_SHORTCUTS_OFS) next_sc = pwdata[1:0];
    if (wr && paddr == `IRQ_ENABLE_SET_OFS) next_en = en | pwdata[5:0];
    if (wr && paddr == `IRQ_ENABLE_CLEAR_OFS) next_en = en & ~pwdata[5:0];
  end
  // Shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc <= '0;
      en <= '0;
    end else begin
      sc <= next_sc;
      en <= next_en;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_bb_follow: assert property (byte_start |=> byte_boundary_event)
    else $error("boundary event missing after byte start");
  a_pause_short: assert property (byte_boundary_event && sc[0] |=> pause_task)
    else $error("pause task missing after boundary");
  a_pause_quiet: assert property (!pause_request && !(byte_boundary_event && sc[0]) |=> !pause_task)
    else $error("pause task without cause");
  a_halt_short: assert property (byte_boundary_event && sc[1] |=> halt_task)
    else $error("halt task missing after boundary");
  a_halt_quiet: assert property (!halt_request && !(byte_boundary_event && sc[1]) |=> !halt_task)
    else $error("halt task without cause");
  a_paused_cause: assert property (paused_event |-> $past(read_ack_done))
    else $error("paused event without read ack");
  a_irq_level: assert property (irq == $past(|(event_flags & en)))
    else $error("interrupt level wrong");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer late");
  a_enable_read: assert property (pready && !pwrite && (paddr == `IRQ_ENABLE_SET_OFS ||
    paddr == `IRQ_ENABLE_CLEAR_OFS) |-> prdata == {26'h0, en})
    else $error("enable readback wrong");
  c_both_tasks: cover property (pause_task && halt_task);
  c_paused: cover property (paused_event);
  c_irq: cover property (irq);
endmodule
`default_nettype wire

// >>> two_wire_pkg.sv
// Types shared by the two-wire event and interrupt block
package two_wire_pkg;

  // One bit per event source
  typedef logic [5:0] event_vec_t;

  // Register bus answer sequencing
  typedef enum logic {
    apb_idle,
    apb_answer
  } apb_phase_e;

endpackage

// >>> two_wire_regs.svh
// Register offsets, field positions and reset values of the two-wire event block
`ifndef TWO_WIRE_REGS_SVH
`define TWO_WIRE_REGS_SVH

// Byte offsets on the register bus
`define EVENT_TASK_SHORTCUTS_OFS 12'h200
`define IRQ_ENABLE_SET_OFS       12'h304
`define IRQ_ENABLE_CLEAR_OFS     12'h308
`define EVENT_STATUS_OFS         12'h310
`define EVENT_STATUS_CLEAR_OFS   12'h314

// Shortcut field positions
`define SC_PAUSE_BIT 0
`define SC_HALT_BIT  1
`define SC_WIDTH     2

// Event bit positions, shared by enable, status and clear registers
`define EV_HALT_DONE_BIT 0
`define EV_RX_READY_BIT  1
`define EV_TX_SENT_BIT   2
`define EV_ERROR_BIT     3
`define EV_BOUNDARY_BIT  4
`define EV_PAUSED_BIT    5
`define EV_COUNT         6

// Reset values
`define SHORTCUTS_RESET  2'h0
`define IRQ_ENABLE_RESET 6'h00

`endif
